// ---- rtl/dmc_params.svh ----
// Constants for the default memory space control block.
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH
`define DMC_REG_OFFSET   8'hc6
`define DMC_REG_RESET    16'h0000
`define DMC_REG_WMASK    16'h3fec
`define DMC_WAIT_LSB     10
`define DMC_BURST_BIT    9
`define DMC_CORE_ACK_BIT 8
`define DMC_PORT_LSB     6
`define DMC_ALT_ACK_BIT  5
`define DMC_WR_HOLD_BIT  3
`define DMC_RD_HOLD_BIT  2
`define DMC_PORT_32      2'h0
`define DMC_PORT_8       2'h1
`define DMC_SIZ_LONG     2'h0
`define DMC_SIZ_BYTE     2'h1
`define DMC_SIZ_WORD     2'h2
`define DMC_SIZ_LINE     2'h3
`define DMC_LANES_32     4'hf
`define DMC_LANES_16     4'hc
`define DMC_LANES_8      4'h8
`endif

// ---- rtl/dmc_pkg.sv ----
// Types shared by the default memory space control block.
package dmc_pkg;
	typedef enum logic [3:0] {
		DMC_IDLE = 4'h1,
		DMC_WAIT = 4'h2,
		DMC_HOLD = 4'h4,
		DMC_DONE = 4'h8
	} dmc_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        write;
		logic        alt;
		logic [1:0]  size;
	} dmc_req_t;

	typedef struct packed {
		logic [3:0] wait_count;
		logic       burst_allow;
		logic       core_auto_ack;
		logic [1:0] port_width_sel;
		logic       alt_master_auto_ack;
		logic       write_addr_hold;
		logic       read_addr_hold;
	} dmc_cfg_t;
endpackage : dmc_pkg

// ---- rtl/dmc_wait_timer.sv ----
// Wait state down counter for one beat of a default space access.
`timescale 1ns/100ps
`default_nettype none
module dmc_wait_timer #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] count,
	output logic                  expired
);
	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;

	assign cnt_nxt = load ? count : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
	assign expired = (cnt_r == '0);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end
endmodule : dmc_wait_timer
`default_nettype wire

// ---- rtl/dmc_top.sv ----
// Default memory space control: register, wait states, acknowledge, port width, hold.
//
// Behaviour
// - Core access with core_auto_ack inserts wait_count states then acknowledges internally.
// - External transfer_ack_n before the wait states elapse ends the core cycle.
// - Alternate master access with alt_master_auto_ack waits wait_count states then acknowledges.
// - With burst_allow clear, wide transfers split into separate port-sized transfers.
// - With burst_allow set, wide transfers run as one burst of port-sized beats.
// - With core_auto_ack clear, core accesses wait for an external acknowledge.
// - With core_auto_ack set, every unmapped core access completes normally.
// - Port select 00 is 32-bit, 01 is 8-bit high lane, 1x is 16-bit high.
// - With alt_master_auto_ack clear, transfer_ack_n is not driven; wait externally.
// - With alt_master_auto_ack set, drive transfer_ack_n and assert it after wait_count.
// - With alt_master_auto_ack set, unmapped alternate master accesses complete normally.
// - write_addr_hold set holds address, data and attributes one cycle after termination.
// - read_addr_hold set holds the address one cycle after termination.
// - Addresses outside chip-select and DRAM regions are default memory.
// - Control register is 16 bits, read/write, reset to zero.
`include "dmc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module dmc_top
	import dmc_pkg::*;
#(
	parameter int WAIT_WIDTH = 4
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        reg_sel,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic        req_valid,
	input  wire dmc_req_t    req,
	input  wire logic        hit_cs,
	input  wire logic        hit_dram,
	output logic             req_ready,
	input  wire logic        transfer_ack_n_in,
	input  wire logic        async_transfer_ack_n,
	input  wire logic        transfer_error_ack_n,
	input  wire logic [31:0] bus_rdata,
	output logic             transfer_ack_n_out,
	output logic             transfer_ack_n_oe,
	output logic             core_ack,
	output logic             beat_end,
	output logic             xfer_done,
	output logic             xfer_error,
	output logic [31:0]      bus_addr,
	output logic [31:0]      bus_wdata,
	output logic             bus_active,
	output logic             bus_write,
	output logic             addr_hold,
	output logic [3:0]       lane_en,
	output logic             burst,
	output logic [31:0]      rdata
);
	logic [15:0] ctrl_r;
	dmc_cfg_t    cfg;
	dmc_state_t  state_r;
	dmc_state_t  state_nxt;
	dmc_req_t    cur_r;
	dmc_cfg_t    cap_r;
	logic [4:0]  beats_r;
	logic        err_r;
	logic        core_ack_r;
	logic        beat_end_r;
	logic        done_r;
	logic        ack_out_r;
	logic        ack_oe_r;
	logic        ready_r;
	logic        active_r;
	logic        hold_r;
	logic [3:0]  lane_r;
	logic        burst_r;
	logic [31:0] addr_r;
	logic [31:0] rdata_r;
	logic [15:0] rd_r;
	logic        expired;

	// Register decode and field split.
	wire reg_hit   = reg_sel && (reg_addr == `DMC_REG_OFFSET);
	wire reg_write = reg_hit && reg_wr;
	assign cfg.wait_count          = ctrl_r[`DMC_WAIT_LSB +: 4];
	assign cfg.burst_allow         = ctrl_r[`DMC_BURST_BIT];
	assign cfg.core_auto_ack       = ctrl_r[`DMC_CORE_ACK_BIT];
	assign cfg.port_width_sel      = ctrl_r[`DMC_PORT_LSB +: 2];
	assign cfg.alt_master_auto_ack = ctrl_r[`DMC_ALT_ACK_BIT];
	assign cfg.write_addr_hold     = ctrl_r[`DMC_WR_HOLD_BIT];
	assign cfg.read_addr_hold      = ctrl_r[`DMC_RD_HOLD_BIT];

	// Default space is whatever no chip select and no DRAM bank claims.
	wire is_default = !hit_cs && !hit_dram;
	wire accept     = (state_r == DMC_IDLE) && req_valid && is_default;

	// Port width: lanes and bytes per beat.
	wire [3:0] new_lanes = (cfg.port_width_sel == `DMC_PORT_32) ? `DMC_LANES_32 :
	                       (cfg.port_width_sel == `DMC_PORT_8)  ? `DMC_LANES_8 :
	                       `DMC_LANES_16;
	wire [1:0] new_shift = (cfg.port_width_sel == `DMC_PORT_32) ? 2'h2 :
	                       (cfg.port_width_sel == `DMC_PORT_8)  ? 2'h0 : 2'h1;
	wire [4:0] size_bytes = (req.size == `DMC_SIZ_BYTE) ? 5'h01 :
	                        (req.size == `DMC_SIZ_WORD) ? 5'h02 :
	                        (req.size == `DMC_SIZ_LONG) ? 5'h04 : 5'h10;
	wire [4:0] new_beats_raw = size_bytes >> new_shift;
	wire [4:0] new_beats = (new_beats_raw == 5'h00) ? 5'h01 : new_beats_raw;
	wire       wide      = (new_beats > 5'h01);
	wire [1:0] cap_shift = (cap_r.port_width_sel == `DMC_PORT_32) ? 2'h2 :
	                       (cap_r.port_width_sel == `DMC_PORT_8)  ? 2'h0 : 2'h1;
	wire [31:0] addr_step = 32'h1 << cap_shift;

	// Termination of one beat.
	wire int_core = !cur_r.alt && cap_r.core_auto_ack && expired;
	wire int_alt  = cur_r.alt && cap_r.alt_master_auto_ack && expired;
	wire ext_ack  = !transfer_ack_n_in && !(cur_r.alt && cap_r.alt_master_auto_ack);
	wire ext_term = ext_ack || !async_transfer_ack_n || !transfer_error_ack_n;
	wire term     = (state_r == DMC_WAIT) && (int_core || int_alt || ext_term);
	wire need_hold = cur_r.write ? cap_r.write_addr_hold : cap_r.read_addr_hold;
	wire last_beat = (beats_r == 5'h01);
	wire next_beat = (term && !need_hold && !last_beat) ||
	                 ((state_r == DMC_HOLD) && !last_beat);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			DMC_IDLE: begin
				if (accept)
					state_nxt = DMC_WAIT;
			end
			DMC_WAIT: begin
				if (term && need_hold)
					state_nxt = DMC_HOLD;
				else if (term && last_beat)
					state_nxt = DMC_DONE;
			end
			DMC_HOLD: begin
				state_nxt = last_beat ? DMC_DONE : DMC_WAIT;
			end
			DMC_DONE: begin
				state_nxt = DMC_IDLE;
			end
			default: begin
				state_nxt = DMC_IDLE;
			end
		endcase
	end

	dmc_wait_timer #(
		.WIDTH   (WAIT_WIDTH)
	) u_timer (
		.clk     (clk),
		.reset_n (reset_n),
		.load    (accept || next_beat),
		.count   (accept ? cfg.wait_count : cap_r.wait_count),
		.expired (expired)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ctrl_r <= `DMC_REG_RESET;
		else if (reg_write)
			ctrl_r <= reg_wdata & `DMC_REG_WMASK;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rd_r <= `DMC_REG_RESET;
		else
			rd_r <= reg_hit ? ctrl_r : 16'h0000;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= DMC_IDLE;
			cur_r   <= '0;
			cap_r   <= '0;
			beats_r <= 5'h00;
			lane_r  <= 4'h0;
			burst_r <= 1'b0;
			addr_r  <= 32'h0;
		end else begin
			state_r <= state_nxt;
			if (accept) begin
				cur_r   <= req;
				cap_r   <= cfg;
				beats_r <= new_beats;
				lane_r  <= new_lanes;
				burst_r <= wide && cfg.burst_allow;
				addr_r  <= req.addr;
			end else if (next_beat) begin
				beats_r <= beats_r - 5'h01;
				addr_r  <= addr_r + addr_step;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			core_ack_r <= 1'b0;
			beat_end_r <= 1'b0;
			done_r     <= 1'b0;
			err_r      <= 1'b0;
			ack_out_r  <= 1'b1;
			ack_oe_r   <= 1'b0;
			ready_r    <= 1'b1;
			active_r   <= 1'b0;
			hold_r     <= 1'b0;
			rdata_r    <= 32'h0;
		end else begin
			core_ack_r <= (state_r == DMC_WAIT) && int_core && !ext_term;
			beat_end_r <= term;
			done_r     <= (state_nxt == DMC_DONE) && (state_r != DMC_DONE);
			err_r      <= accept ? 1'b0 : (err_r || (term && !transfer_error_ack_n));
			ack_out_r  <= !((state_r == DMC_WAIT) && int_alt);
			ack_oe_r   <= ((state_nxt == DMC_WAIT) &&
			              (accept ? req.alt && cfg.alt_master_auto_ack :
			               cur_r.alt && cap_r.alt_master_auto_ack)) ||
			              ((state_r == DMC_WAIT) && int_alt);
			ready_r    <= (state_nxt == DMC_IDLE);
			active_r   <= (state_nxt == DMC_WAIT);
			hold_r     <= (state_nxt == DMC_HOLD);
			if (term && !cur_r.write)
				rdata_r <= bus_rdata & {{8{lane_r[3]}}, {8{lane_r[2]}},
				                        {8{lane_r[1]}}, {8{lane_r[0]}}};
		end
	end

	assign reg_rdata          = rd_r;
	assign req_ready          = ready_r;
	assign transfer_ack_n_out = ack_out_r;
	assign transfer_ack_n_oe  = ack_oe_r;
	assign core_ack           = core_ack_r;
	assign beat_end           = beat_end_r;
	assign xfer_done          = done_r;
	assign xfer_error         = err_r;
	assign bus_addr           = addr_r;
	assign bus_wdata          = cur_r.wdata;
	assign bus_write          = cur_r.write;
	assign bus_active         = active_r;
	assign addr_hold          = hold_r;
	assign lane_en            = lane_r;
	assign burst              = burst_r;
	assign rdata              = rdata_r;

	wait_core_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r == DMC_WAIT && !cur_r.alt && cap_r.core_auto_ack && expired && !ext_term)
		|=> core_ack_r && beat_end_r)
		else $error("internal acknowledge missing after wait states");
	ext_end_core_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r == DMC_WAIT && !cur_r.alt && !transfer_ack_n_in) |=> beat_end_r)
		else $error("external acknowledge did not end core beat");
	no_auto_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
		core_ack_r |-> $past(cap_r.core_auto_ack) && !$past(cur_r.alt))
		else $error("internal acknowledge without core auto acknowledge");
	alt_drive_en_a: assert property (@(posedge clk) disable iff (!reset_n)
		transfer_ack_n_oe |-> cur_r.alt && cap_r.alt_master_auto_ack)
		else $error("transfer acknowledge driven when not allowed");
	alt_ack_low_a: assert property (@(posedge clk) disable iff (!reset_n)
		!transfer_ack_n_out |-> transfer_ack_n_oe && $past(expired))
		else $error("transfer acknowledge asserted early or undriven");
	hold_cycle_a: assert property (@(posedge clk) disable iff (!reset_n)
		(term && need_hold) |=> addr_hold ##1 !addr_hold)
		else $error("address hold is not exactly one cycle");
	no_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(term && !need_hold) |=> !addr_hold)
		else $error("address hold without enable");
	lane_select_a: assert property (@(posedge clk) disable iff (!reset_n)
		bus_active |-> (lane_en == ((cap_r.port_width_sel == `DMC_PORT_32) ? `DMC_LANES_32 :
		(cap_r.port_width_sel == `DMC_PORT_8) ? `DMC_LANES_8 : `DMC_LANES_16)))
		else $error("byte lanes do not match port width");
	split_burst_a: assert property (@(posedge clk) disable iff (!reset_n)
		burst |-> cap_r.burst_allow)
		else $error("burst flagged while burst not allowed");
	default_only_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r == DMC_IDLE && req_valid && (hit_cs || hit_dram)) |=> state_r == DMC_IDLE)
		else $error("mapped access taken as default memory");
endmodule : dmc_top
`default_nettype wire

// ---- test/dmc_mem_model.sv ----
// Behavioural external memory that answers default space beats.
`timescale 1ns/100ps
`default_nettype none
module dmc_mem_model (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        bus_active,
	input  wire logic        beat_end,
	input  wire logic [31:0] bus_addr,
	input  wire logic        ack_oe,
	input  wire logic        ack_en,
	input  wire logic [3:0]  ack_delay,
	output logic             ack_n,
	output logic [31:0]      rdata
);
	logic [3:0] cnt_r;
	logic       tog_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 4'h0;
			tog_r <= 1'b0;
		end else begin
			tog_r <= !tog_r;
			cnt_r <= (!bus_active || beat_end) ? 4'h0 : cnt_r + 4'h1;
		end
	end
	// The line has a pull-up, so a released acknowledge reads high.
	assign ack_n = !(ack_en && !ack_oe && bus_active && cnt_r == ack_delay);
	// A released data bus shows a pattern that changes every cycle.
	assign rdata = bus_active ? {bus_addr[15:0], ~bus_addr[15:0]} : {32{tog_r}};
endmodule : dmc_mem_model
`default_nettype wire

// ---- test/dmc_top_bench.sv ----
// Self-checking bench for the default memory space control block.
`include "dmc_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("unexpected %s: expected %0h, seen %0h", nm, e, g); \
	end \
end
module dmc_top_bench import dmc_pkg::*;;
	logic        clk, reset_n, reg_sel, reg_wr, req_valid, hit_cs, hit_dram, ack_en, bs;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, cfg, v;
	logic [3:0]  ack_delay, ln, ws, lane_en;
	logic [1:0]  ps, sz;
	logic        b, h, req_ready, ack_out, ack_oe, ack_n, core_ack, beat_end, xfer_done;
	logic        addr_hold, burst, bus_active, tea_n, xfer_error, bus_write, bw;
	logic [31:0] bus_addr, bus_rdata, rdata_o, ra;
	dmc_req_t    req;
	int          n_mismatch, tests_run, cb, cc, ch, co, fc, fa, fb, i;
	dmc_top i_dut (.clk, .reset_n, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
		.req_valid, .req, .hit_cs, .hit_dram, .req_ready,
		.transfer_ack_n_in(ack_n & (ack_oe ? ack_out : 1'b1)),
		.async_transfer_ack_n(1'b1), .transfer_error_ack_n(tea_n), .bus_rdata,
		.transfer_ack_n_out(ack_out), .transfer_ack_n_oe(ack_oe), .core_ack, .beat_end,
		.xfer_done, .xfer_error, .bus_addr, .bus_wdata(), .bus_active, .bus_write,
		.addr_hold, .lane_en, .burst, .rdata(rdata_o));
	dmc_mem_model i_mem (.clk, .reset_n, .bus_active, .beat_end, .bus_addr, .ack_oe,
		.ack_en, .ack_delay, .ack_n, .rdata(bus_rdata));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [15:0] mk(logic [3:0] w, logic bt, aa, logic [1:0] p, logic em, hd);
		return {2'h0, w, bt, aa, p, em, 1'b0, hd, hd, 2'h0};
	endfunction : mk
	function automatic int nbeats(logic [1:0] p, logic [1:0] s);
		int pb = (p == `DMC_PORT_32) ? 4 : (p == `DMC_PORT_8) ? 1 : 2;
		int sb = (s == `DMC_SIZ_LONG) ? 4 : (s == `DMC_SIZ_BYTE) ? 1 : (s == `DMC_SIZ_WORD) ? 2 : 16;
		return (sb > pb) ? sb / pb : 1;
	endfunction : nbeats
	task automatic end_of_test();
		$display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_sel <= 1'b1;
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_sel <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		reg_sel <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge clk);
		reg_sel <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask : rreg
	task automatic run(input logic w, input logic alt, input logic [1:0] s);
		int k;
		{cb, cc, ch, co, fc, fa, fb, bs} = '0;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{$urandom, $urandom, w, alt, s};
		for (k = 0; k < 20 && !req_ready; k++) begin
			@(negedge clk);
		end
		@(posedge clk);
		req_valid <= 1'b0;
		for (k = 1; k < 300; k++) begin
			@(negedge clk);
			cb += beat_end;
			cc += core_ack;
			ch += addr_hold;
			co += ack_oe;
			if (core_ack && fc == 0) fc = k;
			if (!ack_out && fa == 0) fa = k;
			if (beat_end && fb == 0) fb = k;
			if (bus_active) {ln, bs} = {lane_en, bs | burst};
			if (bus_active) {bw, ra} = {bus_write, bus_addr};
			if (xfer_done) break;
		end
		if (k == 300) begin
			n_mismatch++;
			end_of_test();
		end
		`CHK("direction", w, bw)
		if (!w) `CHK("read data", {ra[15:0], ~ra[15:0]} & {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}}, rdata_o)
	endtask : run
	initial begin
		{reset_n, reg_sel, reg_wr, req_valid, hit_cs, hit_dram, ack_en} = '0;
		{reg_addr, reg_wdata, ack_delay, req} = '0;
		tea_n = 1'b1;
		void'($urandom(84881));
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rreg(`DMC_REG_OFFSET);
		`CHK("reset value", `DMC_REG_RESET, v)
		cfg = $urandom;
		wreg(`DMC_REG_OFFSET, cfg);
		rreg(`DMC_REG_OFFSET);
		`CHK("readback", cfg & `DMC_REG_WMASK, v)
		wreg(8'hc4, 16'hffff);
		rreg(8'hc4);
		`CHK("unmapped read", 16'h0000, v)
		$display("register test done");
		for (i = 0; i < 6; i++) begin
			ws = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
			wreg(`DMC_REG_OFFSET, mk(ws, 0, 1, 0, 0, 0));
			run(1'($urandom), 1'b0, `DMC_SIZ_LONG);
			`CHK("internal ack cycle", int'(ws) + 2, fc)
			wreg(`DMC_REG_OFFSET, mk(ws, 0, 0, 0, 1, 0));
			run(1'($urandom), 1'b1, `DMC_SIZ_LONG);
			`CHK("alt ack cycle", int'(ws) + 2, fa)
			`CHK("alt ack driven", 1, co > 0)
		end
		$display("wait state test done");
		ack_en <= 1'b1;
		ack_delay <= 4'h2;
		wreg(`DMC_REG_OFFSET, mk(4'hf, 0, 1, 0, 0, 0));
		run(1'b0, 1'b0, `DMC_SIZ_LONG);
		`CHK("early end cycle", 4, fb)
		wreg(`DMC_REG_OFFSET, mk(0, 0, 0, 0, 0, 0));
		run(1'b1, 1'b0, `DMC_SIZ_LONG);
		`CHK("internal acks", 0, cc)
		`CHK("external end", 4, fb)
		run(1'b0, 1'b1, `DMC_SIZ_LONG);
		`CHK("alt drive cycles", 0, co)
		`CHK("alt external end", 4, fb)
		tea_n <= 1'b0;
		wreg(`DMC_REG_OFFSET, mk(4'hf, 0, 0, 0, 1, 0));
		run(1'b0, 1'b1, `DMC_SIZ_LONG);
		tea_n <= 1'b1;
		`CHK("error end", 2, fb)
		`CHK("error flag", 1'b1, xfer_error)
		ack_en <= 1'b0;
		$display("external ack test done");
		for (i = 0; i < 16; i++) begin
			{ps, sz} = i[3:0];
			{b, h} = 2'($urandom);
			wreg(`DMC_REG_OFFSET, mk(0, b, 1, ps, 0, h));
			run(1'($urandom), 1'b0, sz);
			`CHK("beats", nbeats(ps, sz), cb)
			`CHK("lanes", ps == 0 ? `DMC_LANES_32 : ps == 1 ? `DMC_LANES_8 : `DMC_LANES_16, ln)
			`CHK("burst", b && nbeats(ps, sz) > 1, bs)
			`CHK("hold cycles", h ? nbeats(ps, sz) : 0, ch)
		end
		$display("port width test done");
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			{hit_cs, hit_dram, req_valid} <= {i == 0, i == 1, 1'b1};
			co = 0;
			repeat (8) @(negedge clk) co += bus_active;
			@(posedge clk);
			{hit_cs, hit_dram, req_valid} <= 3'h0;
			`CHK("ignored request", 0, co)
		end
		$display("region test done");
		end_of_test();
	end
endmodule : dmc_top_bench
`default_nettype wire
